// ---- rtl/eeprom_pkg.sv ----
// Purpose: shared constants and types for the serial eeprom core
// Assumes: 10 MHz system clock
// Notes:   opcode values and write cycle length are chosen here
package eeprom_pkg;
    // array shape
    localparam int WORDS          = 64;
    localparam int WORD_BITS      = 16;
    localparam int BYTE_BITS      = 8;
    localparam int ADDR_BITS_X16  = 6;
    localparam int ADDR_BITS_X8   = 7;
    localparam int CMD_BITS       = 9;
    localparam logic [15:0] MEM_RESET_WORD = 16'hffff;
    localparam logic        EWEN_RESET     = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int WRITE_TIME_NS  = 5000000;
    localparam int WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int BUSY_W         = 17;
    // opcodes after the start bit
    localparam logic [1:0] OP_MISC  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] MISC_EWDS = 2'h0;
    localparam logic [1:0] MISC_EWEN = 2'h3;
    // serial engine states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD  = 5'h02,
        ST_DATA = 5'h04,
        ST_READ = 5'h08,
        ST_DONE = 5'h10
    } state_type;
endpackage

// ---- rtl/input_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   stage one is read only by stage two
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_type;

    sync_type sync_reg;
    sync_type sync_next;

    // shift pins through two stages
    always_comb begin
        sync_next.stage1 = async_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stage2;
endmodule // input_sync
`default_nettype wire

// ---- rtl/eeprom_core.sv ----
// Purpose: device side of a 1-kbit three-wire serial eeprom
// Assumes: serial pins asynchronous, sampled by mclk
// Notes:   array held in flip-flops, write cycle self-timed
//
// What this block does
// RQ1: select high gives 64 words of 16
// RQ2: select low gives 128 words of 8
// RQ3: fixed variant always 64 by 16
// RQ4: chip select enables; three serial wires
// RQ5: read instruction shifts addressed word out
// RQ6: self-timed write, no erase first
// RQ7: write starts only when writes enabled
// RQ8: chip select high after write shows status
// RQ9: sample and shift on serial clock rise
// RQ10: chip select low: ignore input, float output
// RQ11: status low while busy, high when done
// RQ12: master waits for ready before writing
`timescale 1ns/100ps
`default_nettype none
module eeprom_core #(
    parameter int FIXED_ORG    = 0,
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic chip_select,
    input  wire logic serial_clock,
    input  wire logic serial_in,
    input  wire logic word_width_select,
    output logic      serial_out,
    output logic      serial_out_oe
);
    import eeprom_pkg::*;

    typedef struct packed {
        state_type                          state;
        logic [WORDS-1:0][WORD_BITS-1:0]    mem;
        logic [CMD_BITS-1:0]                cmd_sh;
        logic [4:0]                         bit_cnt;
        logic [WORD_BITS-1:0]               data_sh;
        logic                               ewen;
        logic                               wr_pend;
        logic                               status_armed;
        logic [BUSY_W-1:0]                  busy_cnt;
        logic [5:0]                         wr_word;
        logic [WORD_BITS-1:0]               wr_mask;
        logic                               dout;
        logic                               oe;
        logic                               sk_d;
    } core_type;

    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES);

    core_type   st_reg;
    core_type   st_next;
    logic [1:0] rst_pipe_reg;
    logic       rst_n;
    logic [3:0] pins_s;
    logic       cs_s;
    logic       sk_s;
    logic       di_s;
    logic       org_s;
    logic       sk_rise;
    logic       wide;
    logic       busy;
    logic [CMD_BITS-1:0]  new_sh;
    logic [1:0]           op;
    logic [6:0]           addr;
    logic [1:0]           misc;
    logic [WORD_BITS-1:0] new_data;

    // word index of an address in either layout
    function automatic logic [5:0] word_of(input logic [6:0] a,
                                           input logic       w);
        return w ? a[5:0] : a[6:1];
    endfunction

    // lanes touched by an address in either layout
    function automatic logic [15:0] mask_of(input logic [6:0] a,
                                            input logic       w);
        if (w) begin
            return 16'hffff;
        end
        return a[0] ? 16'hff00 : 16'h00ff;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    input_sync #(.WIDTH(4)) u_sync (
        .clk      (mclk),
        .rst_n    (rst_n),
        .async_in ({chip_select, serial_clock, serial_in,
                    word_width_select}),
        .sync_out (pins_s)
    );
    assign {cs_s, sk_s, di_s, org_s} = pins_s;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    assign sk_rise  = sk_s & ~st_reg.sk_d;                 // [RQ9]
    assign wide     = (FIXED_ORG != 0) ? 1'b1 : org_s;     // [RQ1] [RQ2] [RQ3]
    assign busy     = st_reg.busy_cnt != '0;
    assign new_sh   = {st_reg.cmd_sh[CMD_BITS-2:0], di_s};
    assign op       = wide ? new_sh[7:6] : new_sh[8:7];
    assign addr     = wide ? {1'b0, new_sh[5:0]} : new_sh[6:0];
    assign misc     = wide ? addr[5:4] : addr[6:5];
    assign new_data = {st_reg.data_sh[WORD_BITS-2:0], di_s};

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next      = st_reg;
        st_next.sk_d = sk_s;
        // self-timed write: overwrite in place at the end
        if (busy) begin                                    // [RQ6]
            st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
            if (st_reg.busy_cnt == BUSY_W'(1)) begin
                st_next.mem[st_reg.wr_word] =
                    (st_reg.mem[st_reg.wr_word] & ~st_reg.wr_mask) |
                    (st_reg.data_sh & st_reg.wr_mask);
            end
        end
        if (!cs_s) begin
            // deselected: float output, abandon any frame
            st_next.state = ST_IDLE;                       // [RQ4] [RQ10]
            st_next.oe    = 1'b0;
            if (st_reg.wr_pend) begin
                st_next.wr_pend = 1'b0;
                if (st_reg.ewen && !busy) begin            // [RQ7]
                    st_next.busy_cnt     = BUSY_LOAD;
                    st_next.status_armed = 1'b1;
                end
            end
        end else begin
            // status shown while reselected after a write
            if (st_reg.status_armed && st_reg.state == ST_IDLE) begin
                st_next.oe   = 1'b1;                       // [RQ8]
                st_next.dout = ~busy;                      // [RQ11]
            end
            if (sk_rise) begin
                case (st_reg.state)
                    ST_IDLE: begin
                        // start bit; ignored while busy
                        if (di_s && !busy) begin
                            st_next.state        = ST_CMD;
                            st_next.cmd_sh       = '0;
                            st_next.bit_cnt      = 5'h00;
                            st_next.status_armed = 1'b0;
                            st_next.oe           = 1'b0;
                        end
                    end
                    ST_CMD: begin
                        st_next.cmd_sh  = new_sh;
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == (wide ? 5'h07 : 5'h08)) begin
                            st_next.bit_cnt = 5'h00;
                            st_next.wr_word = word_of(addr, wide);
                            st_next.wr_mask = mask_of(addr, wide);
                            case (op)
                                OP_READ: begin             // [RQ5]
                                    st_next.state = ST_READ;
                                    st_next.oe    = 1'b1;
                                    st_next.dout  = 1'b0;
                                    if (wide) begin
                                        st_next.data_sh =
                                            st_reg.mem[addr[5:0]];
                                    end else if (addr[0]) begin
                                        st_next.data_sh = {
                                            st_reg.mem[addr[6:1]][15:8],
                                            8'h00};
                                    end else begin
                                        st_next.data_sh = {
                                            st_reg.mem[addr[6:1]][7:0],
                                            8'h00};
                                    end
                                end
                                OP_WRITE: begin
                                    st_next.state   = ST_DATA;
                                    st_next.data_sh = '0;
                                end
                                OP_ERASE: begin
                                    st_next.state   = ST_DONE;
                                    st_next.data_sh = 16'hffff;
                                    st_next.wr_pend = st_reg.ewen; // [RQ7]
                                end
                                default: begin
                                    st_next.state = ST_DONE;
                                    if (misc == MISC_EWEN) begin
                                        st_next.ewen = 1'b1;
                                    end else if (misc == MISC_EWDS) begin
                                        st_next.ewen = 1'b0;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_DATA: begin
                        st_next.data_sh = new_data;
                        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == (wide ? 5'h0f : 5'h07)) begin
                            st_next.state   = ST_DONE;
                            st_next.wr_pend = st_reg.ewen;     // [RQ7]
                            if (!wide) begin
                                st_next.data_sh = {new_data[7:0],
                                                   new_data[7:0]};
                            end
                        end
                    end
                    ST_READ: begin
                        // msb first, zeros after the last bit
                        st_next.dout    = st_reg.data_sh[15];  // [RQ5]
                        st_next.data_sh = {st_reg.data_sh[14:0], 1'b0};
                    end
                    ST_DONE: begin
                        st_next.state = ST_DONE;
                    end
                    default: begin
                        st_next.state = ST_IDLE;
                    end
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg              <= '0;
            st_reg.state        <= ST_IDLE;
            st_reg.mem          <= {WORDS{MEM_RESET_WORD}};
            st_reg.ewen         <= EWEN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign serial_out    = st_reg.dout;
    assign serial_out_oe = st_reg.oe;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_float;
        !cs_s |=> !serial_out_oe;
    endproperty
    a_float: assert property (p_float) // [RQ10]
        else $error("output driven while deselected");

    property p_idle;
        !cs_s |=> st_reg.state == ST_IDLE;
    endproperty
    a_idle: assert property (p_idle) // [RQ4]
        else $error("frame survived deselect");

    property p_x16_len;
        (cs_s && sk_rise && wide && st_reg.state == ST_CMD &&
         st_reg.bit_cnt == 5'h07) |=> st_reg.state != ST_CMD;
    endproperty
    a_x16_len: assert property (p_x16_len) // [RQ1]
        else $error("x16 command length wrong");

    property p_x8_len;
        (cs_s && sk_rise && !wide && st_reg.state == ST_CMD &&
         st_reg.bit_cnt == 5'h07) |=> st_reg.state == ST_CMD;
    endproperty
    a_x8_len: assert property (p_x8_len) // [RQ2]
        else $error("x8 command ended early");

    property p_fixed;
        (FIXED_ORG != 0 && cs_s && sk_rise && st_reg.state == ST_CMD &&
         st_reg.bit_cnt == 5'h07) |=> st_reg.state != ST_CMD;
    endproperty
    a_fixed: assert property (p_fixed) // [RQ3]
        else $error("fixed variant not x16");

    property p_read;
        (cs_s && sk_rise && st_reg.state == ST_READ) |=>
            serial_out == $past(st_reg.data_sh[15]) && serial_out_oe;
    endproperty
    a_read: assert property (p_read) // [RQ5]
        else $error("read bit not shifted out");

    property p_enable;
        $rose(busy) |-> $past(st_reg.ewen) && !$past(cs_s);
    endproperty
    a_enable: assert property (p_enable) // [RQ7]
        else $error("write started while disabled");

    property p_timed;
        $rose(busy) |=> busy [*8];
    endproperty
    a_timed: assert property (p_timed) // [RQ6]
        else $error("write cycle ended too soon");

    property p_status;
        (cs_s && st_reg.status_armed && st_reg.state == ST_IDLE &&
         !(sk_rise && di_s && !busy)) |=> serial_out_oe;
    endproperty
    a_status: assert property (p_status) // [RQ8]
        else $error("status not driven");

    property p_ready;
        (serial_out_oe && st_reg.status_armed && $past(cs_s)) |->
            serial_out == !$past(busy);
    endproperty
    a_ready: assert property (p_ready) // [RQ11]
        else $error("ready level wrong");

    property p_sample;
        (cs_s && !sk_rise) |=> $stable(st_reg.cmd_sh) &&
            $stable(st_reg.bit_cnt);
    endproperty
    a_sample: assert property (p_sample) // [RQ9]
        else $error("shift without clock rise");
endmodule // eeprom_core
`default_nettype wire

// ---- testbench/serial_master_model.sv ----
// Purpose: bus master model driving the three-wire serial link
// Assumes: called from the bench, mclk at 10 MHz
// Notes:   serial clock 800 ns period, stands low outside frames
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
    input  wire logic mclk,
    input  wire logic serial_out,
    output var logic  chip_select,
    output var logic  serial_clock,
    output var logic  serial_in
);
    // idle levels before the first frame
    initial begin
        chip_select  = 1'b0;
        serial_clock = 1'b0;
        serial_in    = 1'b0;
    end
    // all pin changes land 1 ns after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // open a frame through the select line only
    task automatic select();
        tick(1);
        chip_select = 1'b1;
        tick(3);
    endtask
    // close a frame; data line shows no stale value afterwards
    task automatic deselect();
        tick(1);
        chip_select = 1'b0;
        serial_in   = ~serial_in;
        tick(8);
    endtask
    // msb first, data settled half a period around each rise
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = v[i];
            tick(4);
            serial_clock = 1'b1;
            tick(4);
            serial_clock = 1'b0;
        end
    endtask
    // one rise per bit, sampled just before the next rise
    task automatic recv(output logic [31:0] v, input int n);
        v = '0;
        for (int i = 0; i < n; i++) begin
            serial_in    = ~serial_in;
            serial_clock = 1'b1;
            tick(4);
            serial_clock = 1'b0;
            tick(4);
            v = {v[30:0], serial_out};
        end
    endtask
endmodule // serial_master_model
`default_nettype wire

// ---- testbench/test_three_wire_serial_eeprom_core.sv ----
// Purpose: self-checking bench for the serial eeprom core
// Assumes: short write cycle of 20 mclk for simulation
// Notes:   second instance is the fixed 64x16 variant
`timescale 1ns/100ps
`default_nettype none
module test_three_wire_serial_eeprom_core;
    import eeprom_pkg::*;
    localparam int WCYC = 20;
    logic mclk, reset_n, word_width_select, use_fixed;
    logic chip_select, serial_clock, serial_in, cs_main, cs_fixed;
    logic out_main, oe_main, out_fixed, oe_fixed, out_seen;
    int   miscompares, checks_done;
    ////////////////////////////////////////////////////////////////////
    // select routing and wire level of the data output
    assign cs_main  = chip_select & ~use_fixed;
    assign cs_fixed = chip_select & use_fixed;
    assign out_seen = use_fixed ? (oe_fixed ? out_fixed : 1'bz)
                                : (oe_main ? out_main : 1'bz);
    serial_master_model u_master (.mclk(mclk), .serial_out(out_seen),
        .chip_select(chip_select), .serial_clock(serial_clock),
        .serial_in(serial_in));
    eeprom_core #(.WRITE_CYCLES(WCYC)) u_dut (
        .mclk(mclk), .reset_n(reset_n), .chip_select(cs_main),
        .serial_clock(serial_clock), .serial_in(serial_in),
        .word_width_select(word_width_select),
        .serial_out(out_main), .serial_out_oe(oe_main));
    eeprom_core #(.FIXED_ORG(1), .WRITE_CYCLES(WCYC)) u_fixed (
        .mclk(mclk), .reset_n(reset_n), .chip_select(cs_fixed),
        .serial_clock(serial_clock), .serial_in(serial_in),
        .word_width_select(word_width_select),
        .serial_out(out_fixed), .serial_out_oe(oe_fixed));
    ////////////////////////////////////////////////////////////////////
    // compare and closing report
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // frame helpers: start bit, opcode, address msb first
    function automatic logic x16();
        return word_width_select | use_fixed;
    endfunction
    task automatic command(input logic [1:0] op, input logic [6:0] addr);
        int ab;
        ab = x16() ? ADDR_BITS_X16 : ADDR_BITS_X8;
        u_master.select();
        u_master.send((32'({1'b1, op}) << ab) | 32'(addr), ab + 3);
    endtask
    task automatic write_word(input logic [6:0] a, input logic [15:0] d);
        command(OP_WRITE, a);
        u_master.send(32'(d), x16() ? WORD_BITS : BYTE_BITS);
        u_master.deselect();
    endtask
    task automatic misc(input logic [1:0] two);
        command(OP_MISC, x16() ? {1'b0, two, 4'h0} : {two, 5'h0});
        u_master.deselect();
    endtask
    task automatic read_word(input logic [6:0] a, input logic [15:0] exp);
        logic [31:0] v;
        command(OP_READ, a);
        u_master.tick(2);
        check("dummy bit", 16'(out_seen), 16'h0);
        u_master.recv(v, x16() ? WORD_BITS : BYTE_BITS);
        check("read data", v[15:0], exp);
        u_master.deselect();
        check("output enable", 16'(use_fixed ? oe_fixed : oe_main), 16'h0);
    endtask
    // reselect after a write: busy first, then ready within a bound
    task automatic wait_ready();
        int n;
        u_master.select();
        u_master.tick(2);
        check("busy status", 16'(out_seen), 16'h0);
        n = 0;
        while (out_seen !== 1'b1 && n < 100) begin
            u_master.tick(1);
            n++;
        end
        if (n == 100) begin
            miscompares++;
            $display("MISMATCH ready status expected 1 seen timeout");
            test_done();
        end
        check("ready status", 16'(out_seen), 16'h1);
        u_master.deselect();
    endtask
    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_read();
        check("oe after reset", 16'(oe_main), 16'h0);
        read_word(7'h05, 16'hffff);
        $display("done: reset read");
    endtask
    task automatic t_write_locked();
        write_word(7'h03, 16'h1234);
        u_master.tick(3 * WCYC);
        read_word(7'h03, 16'hffff);
        $display("done: write while locked");
    endtask
    task automatic t_write_erase();
        misc(2'b11);
        write_word(7'h03, 16'ha5c3);
        wait_ready();
        write_word(7'h03, 16'h0f0f);
        wait_ready();
        read_word(7'h03, 16'h0f0f);
        command(OP_ERASE, 7'h03);
        u_master.deselect();
        wait_ready();
        read_word(7'h03, 16'hffff);
        $display("done: write and erase");
    endtask
    task automatic t_byte_mode();
        word_width_select = 1'b0;
        write_word(7'h07, 16'h0012);
        wait_ready();
        write_word(7'h06, 16'h0034);
        wait_ready();
        read_word(7'h07, 16'h0012);
        read_word(7'h06, 16'h0034);
        word_width_select = 1'b1;
        read_word(7'h03, 16'h1234);
        $display("done: byte mode");
    endtask
    task automatic t_deselected();
        u_master.send({23'h0, 1'b1, OP_ERASE, 6'h03}, 9);
        check("oe while idle", 16'(oe_main), 16'h0);
        u_master.tick(3 * WCYC);
        read_word(7'h03, 16'h1234);
        $display("done: deselected clocks");
    endtask
    task automatic t_relock();
        misc(2'b00);
        write_word(7'h03, 16'h0000);
        u_master.tick(3 * WCYC);
        read_word(7'h03, 16'h1234);
        $display("done: relock");
    endtask
    task automatic t_fixed();
        // width pin low must not change the fixed variant's layout
        use_fixed         = 1'b1;
        word_width_select = 1'b0;
        misc(2'b11);
        write_word(7'h01, 16'hbeef);
        wait_ready();
        read_word(7'h01, 16'hbeef);
        use_fixed         = 1'b0;
        word_width_select = 1'b1;
        $display("done: fixed variant");
    endtask
    ////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // reset, then the scenarios in order
    initial begin
        miscompares       = 0;
        checks_done       = 0;
        reset_n           = 1'b0;
        word_width_select = 1'b1;
        use_fixed         = 1'b0;
        repeat (3) @(posedge mclk);
        #1 reset_n = 1'b1;
        u_master.tick(10);
        t_reset_read();
        t_write_locked();
        t_write_erase();
        t_byte_mode();
        t_deselected();
        t_relock();
        t_fixed();
        test_done();
    end
endmodule // test_three_wire_serial_eeprom_core
`default_nettype wire
